// file: core/pecs_counter_bank.sv
// upper event counter bank: counters 6 to 15 with selection and filtering
// assumes event strobes are one-cycle pulses on ref_clk; register reads
// answer one cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none

module pecs_counter_bank
  import pecs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire pecs_spr_req_t spr_req,
  output logic [31:0] spr_rdata,
  input wire pecs_pipe_ev_t pipe_ev,
  input wire pecs_sw_ev_t sw_ev,
  input wire pecs_net_ev_t gen_net_ev,
  input wire pecs_net_ev_t mem_net_ev,
  output logic [15:6] event_trigger,
  output logic event_irq
);

  // ************************************************************
  // helper functions
  // ************************************************************

  // meaning of one network port event as chosen by its field
  function automatic logic net_event(input logic [2:0] code, input pecs_net_ev_t n,
                                     input int d);
    logic r;
    r = 1'b0;
    case (code)
      NEV_OUT_BLOCK: r = n.out_blocked[d];
      NEV_ALL_OUT: r = |n.route[d];
      NEV_IN_STUCK: r = n.in_stuck[d];
      default: r = n.route[d][code - 3'h1];
    endcase
    return r;
  endfunction

  // pc filter: word address compared with the stored fifteen bits
  function automatic logic pc_ok(input logic [31:0] flt, input logic [31:0] pc);
    return !flt[FLT_MODE] || (pc[16:2] == flt[15:1]);
  endfunction

  function automatic logic is_cnt(input logic [5:0] addr, input int k);
    return addr == SPR_CNT_BASE + 6'(k);
  endfunction

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [31:0] filter_reg, filter_next;
  logic [31:0] select_reg, select_next;
  logic [31:0] netcfg_reg, netcfg_next;

  // plain stores from the spr port
  always_comb
  begin
    filter_next = filter_reg;
    select_next = select_reg;
    netcfg_next = netcfg_reg;
    if (spr_req.wr && spr_req.addr == SPR_FILTER)
      filter_next = spr_req.wdata;
    if (spr_req.wr && spr_req.addr == SPR_SELECT)
      select_next = spr_req.wdata;
    if (spr_req.wr && spr_req.addr == SPR_NETCFG)
      netcfg_next = spr_req.wdata;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filter_reg <= FILTER_RST;
      select_reg <= SELECT_RST;
      netcfg_reg <= NETCFG_RST;
    end
    else
    begin
      filter_reg <= filter_next;
      select_reg <= select_next;
      netcfg_reg <= netcfg_next;
    end
  end

  // ************************************************************
  // event selection
  // ************************************************************
  logic [15:6] ev;
  logic [15:6] wr_hit;
  logic [9:0] nev;
  logic [31:0] ev_pc [6:15];
  logic m_rf, m_ex;

  // network events, ordered gen p,w,s,e,n then mem p,w,s,e,n
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      nev[i] = net_event(netcfg_reg[3*i +: 3], gen_net_ev, i);
      nev[i+5] = net_event(netcfg_reg[3*(i+5) +: 3], mem_net_ev, i);
    end
  end

  // pipeline events other than issue pass the filter; switch, issue and network events never see it
  always_comb
  begin
    m_rf = pc_ok(filter_reg, pipe_ev.rf_pc);
    m_ex = pc_ok(filter_reg, pipe_ev.ex_pc);
    ev = '0;
    ev[6] = m_ex && (select_reg[SEL_SPB] ? pipe_ev.static_predict_bit_miss
                                          : pipe_ev.mispredict);
    ev[7] = sw_ev.stall;
    ev[8] = sw_ev.poss_mispredict;
    ev[9] = sw_ev.mispredict;
    ev[11] = (select_reg[SEL_FU] && pipe_ev.fu_stall && m_rf)
           || (select_reg[SEL_PRI_P] && nev[DIR_P])
           || (select_reg[SEL_STO_P] && nev[5+DIR_P])
           || (select_reg[SEL_ISS1] && pipe_ev.issue);
    ev[12] = (select_reg[SEL_NC] && pipe_ev.noncache_stall && m_rf)
           || (select_reg[SEL_PRI_W] && nev[DIR_W])
           || (select_reg[SEL_STO_W] && nev[5+DIR_W]);
    ev[13] = (select_reg[SEL_IMEM] && pipe_ev.imem_op_issue && m_rf)
           || (select_reg[SEL_PRI_S] && nev[DIR_S])
           || (select_reg[SEL_STO_S] && nev[5+DIR_S])
           || (select_reg[SEL_ISS2] && pipe_ev.issue);
    ev[14] = (m_rf && ((select_reg[SEL_SO] && pipe_ev.static_out_stall)
           || (select_reg[SEL_GO] && pipe_ev.general_dyn_out_port_stall)
           || (select_reg[SEL_MO] && pipe_ev.memory_dyn_out_port_stall)))
           || (select_reg[SEL_PRI_E] && nev[DIR_E])
           || (select_reg[SEL_STO_E] && nev[5+DIR_E]);
    ev[15] = (m_rf && ((select_reg[SEL_SI] && pipe_ev.static_net_in_port_stall)
           || (select_reg[SEL_SI2] && pipe_ev.static_net_in_port_second_stall)
           || (select_reg[SEL_GI] && pipe_ev.general_dyn_in_port_stall)
           || (select_reg[SEL_MI] && pipe_ev.memory_dyn_in_port_stall)))
           || (select_reg[SEL_PRI_N] && nev[DIR_N])
           || (select_reg[SEL_STO_N] && nev[5+DIR_N]);
    // per-counter enable gates counting and trigger setting, never a trigger already set
    for (int k = CNT_LO; k <= CNT_HI; k++)
    begin
      ev[k] = ev[k] && filter_reg[FLT_EN_LO + k - CNT_LO] && (k != LFSR_IDX);
      wr_hit[k] = spr_req.wr && is_cnt(spr_req.addr, k);
    end
  end

  // pc captured per counter: switch pc for switch events, rf pc for stalls
  always_comb
  begin
    for (int k = CNT_LO; k <= CNT_HI; k++)
      ev_pc[k] = pipe_ev.rf_pc;
    ev_pc[6] = pipe_ev.ex_pc;
    ev_pc[7] = sw_ev.pc;
    ev_pc[8] = sw_ev.pc;
    ev_pc[9] = sw_ev.pc;
  end

  // ************************************************************
  // counters and triggers
  // ************************************************************
  logic [31:0] cnt_reg [6:15];
  logic [31:0] cnt_next [6:15];
  logic [15:6] trig_reg, trig_next;
  logic irq_reg, irq_next;
  logic [31:0] dec;

  // a write reloads and releases the trigger, but a same-cycle wrap still sets it
  always_comb
  begin
    dec = '0;
    for (int k = CNT_LO; k <= CNT_HI; k++)
    begin
      cnt_next[k] = cnt_reg[k];
      trig_next[k] = trig_reg[k] && !wr_hit[k];
      if (k == LFSR_IDX)
        cnt_next[k] = {cnt_reg[k][TAP_A] ^ cnt_reg[k][TAP_B] ^ cnt_reg[k][TAP_C]
                       ^ cnt_reg[k][TAP_D], cnt_reg[k][31:1]};
      else if (ev[k])
      begin
        dec = cnt_reg[k] - 32'h1;
        cnt_next[k] = {ev_pc[k][17:2], dec[15:0]};
        if (cnt_reg[k] == '0)
          trig_next[k] = 1'b1;
      end
      if (wr_hit[k])
        cnt_next[k] = spr_req.wdata;
    end
    irq_next = |trig_reg;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int k = CNT_LO; k <= CNT_HI; k++)
        cnt_reg[k] <= (k == LFSR_IDX) ? LFSR_SEED : CNT_RST;
      trig_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      for (int k = CNT_LO; k <= CNT_HI; k++)
        cnt_reg[k] <= cnt_next[k];
      trig_reg <= trig_next;
      irq_reg <= irq_next;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  logic [31:0] rdata_reg, rdata_next;

  // unmapped indices read zero; data holds until the next read
  always_comb
  begin
    rdata_next = rdata_reg;
    if (spr_req.rd)
    begin
      rdata_next = '0;
      if (spr_req.addr == SPR_FILTER)
        rdata_next = filter_reg;
      if (spr_req.addr == SPR_SELECT)
        rdata_next = select_reg;
      if (spr_req.addr == SPR_NETCFG)
        rdata_next = netcfg_reg;
      for (int k = CNT_LO; k <= CNT_HI; k++)
        if (is_cnt(spr_req.addr, k))
          rdata_next = cnt_reg[k];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  assign spr_rdata = rdata_reg;
  assign event_trigger = trig_reg;
  assign event_irq = irq_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_lfsr_step;
    !wr_hit[10] |=> cnt_reg[10] == {$past(cnt_reg[10][31] ^ cnt_reg[10][30]
      ^ cnt_reg[10][10] ^ cnt_reg[10][0]), $past(cnt_reg[10][31:1])};
  endproperty
  a_lfsr_step: assert property (p_lfsr_step) else $error("lfsr step wrong");

  property p_static_predict_bit_only;
    select_reg[SEL_SPB] && !pipe_ev.static_predict_bit_miss && !wr_hit[6]
      |=> $stable(cnt_reg[6]);
  endproperty
  a_static_predict_bit_only: assert property (p_static_predict_bit_only) else $error("counter 6 moved");

  property p_switch_pc;
    sw_ev.stall && filter_reg[FLT_EN_LO + 1] && !wr_hit[7]
      |=> cnt_reg[7][31:16] == $past(sw_ev.pc[17:2])
       && cnt_reg[7][15:0] == $past(cnt_reg[7][15:0]) - 16'h1;
  endproperty
  a_switch_pc: assert property (p_switch_pc) else $error("switch count wrong");

  property p_wrap_trig;
    ev[13] && cnt_reg[13] == '0 |=> trig_reg[13] ##1 event_irq;
  endproperty
  a_wrap_trig: assert property (p_wrap_trig) else $error("no trigger or irq");

  property p_trig_hold;
    trig_reg[13] && !wr_hit[13] |=> trig_reg[13];
  endproperty
  a_trig_hold: assert property (p_trig_hold) else $error("trigger dropped");

  property p_issue_nopc;
    select_reg[SEL_ISS1] && pipe_ev.issue && filter_reg[FLT_EN_LO + 5] && !wr_hit[11]
      |=> cnt_reg[11][15:0] == $past(cnt_reg[11][15:0]) - 16'h1;
  endproperty
  a_issue_nopc: assert property (p_issue_nopc) else $error("issue not counted");

  property p_disabled;
    !filter_reg[FLT_EN_LO + 5] && !wr_hit[11] |=> $stable(cnt_reg[11]);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled counter moved");

  property p_stuck_in;
    netcfg_reg[5:3] == NEV_IN_STUCK && gen_net_ev.in_stuck[DIR_W]
      && select_reg[SEL_PRI_W] && filter_reg[FLT_EN_LO + 6] && !wr_hit[12]
      |=> cnt_reg[12] != $past(cnt_reg[12]);
  endproperty
  a_stuck_in: assert property (p_stuck_in) else $error("net event missed");

  property p_pc_filter;
    filter_reg[FLT_MODE] && pipe_ev.rf_pc[16:2] != filter_reg[15:1]
      && select_reg[SEL_FU] && pipe_ev.fu_stall && !(select_reg[SEL_ISS1] && pipe_ev.issue)
      && !(select_reg[SEL_PRI_P] && nev[DIR_P]) && !(select_reg[SEL_STO_P] && nev[5+DIR_P])
      && !wr_hit[11] |=> $stable(cnt_reg[11]);
  endproperty
  a_pc_filter: assert property (p_pc_filter) else $error("filtered event counted");

  // any live trigger must show on the interrupt one cycle later
  property p_irq_follow;
    (|trig_reg) |=> event_irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq missing");

  // several stall kinds in one cycle still take a single step
  property p_single_step;
    ev[14] && !wr_hit[14] |=> cnt_reg[14][15:0] == $past(cnt_reg[14][15:0]) - 16'h1;
  endproperty
  a_single_step: assert property (p_single_step) else $error("counter 14 step wrong");

  // stall and network events on counter 15 capture the register-fetch pc
  property p_rf_capture;
    ev[15] && !wr_hit[15] |=> cnt_reg[15][31:16] == $past(pipe_ev.rf_pc[17:2]);
  endproperty
  a_rf_capture: assert property (p_rf_capture) else $error("counter 15 pc wrong");

  c_wrap: cover property (ev[14] && cnt_reg[14] == '0 ##2 event_irq);
  c_rewrite: cover property (trig_reg[6] ##1 wr_hit[6]);
  c_route: cover property (select_reg[SEL_PRI_N] && nev[DIR_N] && ev[15]);
  c_multi: cover property (ev[15] && pipe_ev.static_net_in_port_stall
    && pipe_ev.memory_dyn_in_port_stall);

endmodule

`default_nettype wire

// file: core/pecs_pkg.sv
// constants, register indices and carrier types for the upper event counter bank
// assumes one core clock; events arrive as same-clock strobes from pipeline,
// switch and routers; software reaches the registers through the spr port
package pecs_pkg;

  // ************************************************************
  // register indices on the special-purpose register port
  // ************************************************************
  localparam logic [5:0] SPR_FILTER = 6'h00;
  localparam logic [5:0] SPR_SELECT = 6'h01;
  localparam logic [5:0] SPR_NETCFG = 6'h02;
  localparam logic [5:0] SPR_CNT_BASE = 6'h10;
  localparam int CNT_LO = 6;
  localparam int CNT_HI = 15;
  localparam int LFSR_IDX = 10;

  // ************************************************************
  // values after reset
  // ************************************************************
  localparam logic [31:0] FILTER_RST = 32'h03ff_0000;
  localparam logic [31:0] SELECT_RST = 32'h0000_0000;
  localparam logic [31:0] NETCFG_RST = 32'h0000_0000;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [31:0] LFSR_SEED = 32'h0000_0001;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int FLT_MODE = 0;
  localparam int FLT_EN_LO = 16;
  localparam int SEL_SPB = 2, SEL_FU = 3, SEL_PRI_P = 4, SEL_STO_P = 5;
  localparam int SEL_NC = 6, SEL_PRI_W = 7, SEL_STO_W = 8;
  localparam int SEL_IMEM = 9, SEL_PRI_S = 10, SEL_STO_S = 11;
  localparam int SEL_SO = 12, SEL_GO = 13, SEL_MO = 14, SEL_PRI_E = 15, SEL_STO_E = 16;
  localparam int SEL_SI = 17, SEL_SI2 = 18, SEL_GI = 19, SEL_MI = 20;
  localparam int SEL_PRI_N = 21, SEL_STO_N = 22, SEL_ISS1 = 23, SEL_ISS2 = 24;
  localparam int TAP_A = 31, TAP_B = 30, TAP_C = 10, TAP_D = 0;

  // network event field codes; port order proc, west, south, east, north
  localparam logic [2:0] NEV_OUT_BLOCK = 3'h0;
  localparam logic [2:0] NEV_ALL_OUT = 3'h6;
  localparam logic [2:0] NEV_IN_STUCK = 3'h7;
  localparam int DIR_P = 0, DIR_W = 1, DIR_S = 2, DIR_E = 3, DIR_N = 4;

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [31:0] wdata;
  } pecs_spr_req_t;

  typedef struct packed {
    logic mispredict;
    logic static_predict_bit_miss;
    logic fu_stall;
    logic noncache_stall;
    logic imem_op_issue;
    logic static_out_stall;
    logic general_dyn_out_port_stall;
    logic memory_dyn_out_port_stall;
    logic static_net_in_port_stall;
    logic static_net_in_port_second_stall;
    logic general_dyn_in_port_stall;
    logic memory_dyn_in_port_stall;
    logic issue;
    logic [31:0] rf_pc;
    logic [31:0] ex_pc;
  } pecs_pipe_ev_t;

  typedef struct packed {
    logic stall;
    logic poss_mispredict;
    logic mispredict;
    logic [31:0] pc;
  } pecs_sw_ev_t;

  // route[d][x]: a word went from input port d to output port x this cycle
  typedef struct packed {
    logic [4:0] out_blocked;
    logic [4:0] in_stuck;
    logic [4:0][4:0] route;
  } pecs_net_ev_t;

endpackage

// file: verif/pecs_event_model.sv
// event source model: pipeline, switch and router strobes for the counter bank
// assumes the bench calls fire from one thread, one event cycle per call
`timescale 1ns/1ns
`default_nettype none

module pecs_event_model
  import pecs_pkg::*;
(
  input wire logic ref_clk,
  output pecs_pipe_ev_t pipe_ev,
  output pecs_sw_ev_t sw_ev,
  output pecs_net_ev_t gen_net_ev,
  output pecs_net_ev_t mem_net_ev
);
  // ********
  // strobes
  // ********
  // quiet at time zero so the bank sees no event during reset
  initial
  begin
    pipe_ev = '0;
    sw_ev = '0;
    gen_net_ev = '0;
    mem_net_ev = '0;
  end

  // one event cycle after a falling edge; afterwards the pc lines show the
  // inverse so a stale pc can never pass for the captured one
  task automatic fire(input pecs_pipe_ev_t p, input pecs_sw_ev_t s,
                      input pecs_net_ev_t g, input pecs_net_ev_t m);
    @(negedge ref_clk);
    pipe_ev = p;
    sw_ev = s;
    gen_net_ev = g;
    mem_net_ev = m;
    @(negedge ref_clk);
    pipe_ev = '0;
    pipe_ev.rf_pc = ~p.rf_pc;
    pipe_ev.ex_pc = ~p.ex_pc;
    sw_ev = '0;
    sw_ev.pc = ~s.pc;
    gen_net_ev = '0;
    mem_net_ev = '0;
  endtask
endmodule

`default_nettype wire

// file: verif/perf_event_counter_select_tb.sv
// self-checking bench for the upper event counter bank
// assumes pecs_event_model drives the event side; spr port driven here
`timescale 1ns/1ns
`default_nettype none

module perf_event_counter_select_tb
  import pecs_pkg::*;
;
  logic ref_clk;
  logic arst_n;
  pecs_spr_req_t spr_req;
  logic [31:0] spr_rdata;
  logic [31:0] rd_val;
  logic [31:0] a;
  pecs_pipe_ev_t pipe_ev, p;
  pecs_sw_ev_t sw_ev, s;
  pecs_net_ev_t gen_net_ev, mem_net_ev, g, m;
  logic [15:6] event_trigger;
  logic event_irq;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  pecs_counter_bank i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .spr_req(spr_req),
    .spr_rdata(spr_rdata), .pipe_ev(pipe_ev), .sw_ev(sw_ev), .gen_net_ev(gen_net_ev),
    .mem_net_ev(mem_net_ev), .event_trigger(event_trigger), .event_irq(event_irq));
  pecs_event_model i_src (.ref_clk(ref_clk), .pipe_ev(pipe_ev), .sw_ev(sw_ev),
    .gen_net_ev(gen_net_ev), .mem_net_ev(mem_net_ev));

  // ********
  // clock and hang guard
  // ********
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // the whole run needs well under 2000 cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      results();
    end
  end

  // ********
  // shared tasks
  // ********
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] ad, input logic [31:0] d);
    @(negedge ref_clk);
    spr_req.wr = 1'b1;
    spr_req.addr = ad;
    spr_req.wdata = d;
    @(negedge ref_clk);
    spr_req.wr = 1'b0;
  endtask

  // data is sampled two edges on, where it stands whatever the latency reading
  task automatic rd(input logic [5:0] ad);
    @(negedge ref_clk);
    spr_req.rd = 1'b1;
    spr_req.addr = ad;
    @(negedge ref_clk);
    spr_req.rd = 1'b0;
    @(negedge ref_clk);
    rd_val = spr_rdata;
  endtask

  // low half only: the high half carries whatever pc was captured
  task automatic rdlo(input int k, input logic [15:0] e);
    rd(SPR_CNT_BASE + 6'(k));
    chk({16'h0, rd_val[15:0]}, {16'h0, e});
  endtask

  task automatic clr();
    p = '0;
    s = '0;
    g = '0;
    m = '0;
  endtask

  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[31] ^ x[30] ^ x[10] ^ x[0], x[31:1]};
  endfunction

  // ********
  // scenarios
  // ********
  task automatic t_regs();
    rd(SPR_FILTER);
    chk(rd_val, 32'h03ff_0000);
    rd(SPR_NETCFG);
    chk(rd_val, 32'h0);
    wr(6'h05, 32'hffff_ffff);
    rd(6'h05);
    chk(rd_val, 32'h0);
    wr(SPR_SELECT, 32'h01ff_fffc);
    rd(SPR_SELECT);
    chk(rd_val, 32'h01ff_fffc);
  endtask

  task automatic t_wrap();
    wr(SPR_SELECT, 32'h0100_0000);
    wr(SPR_CNT_BASE + 6'd13, 32'h0);
    clr();
    p.issue = 1'b1;
    p.rf_pc = 32'h0001_2348;
    i_src.fire(p, s, g, m);
    chk({31'h0, event_trigger[13]}, 32'h1);
    chk({31'h0, event_irq}, 32'h0);
    @(negedge ref_clk);
    chk({31'h0, event_irq}, 32'h1);
    rd(SPR_CNT_BASE + 6'd13);
    chk(rd_val, 32'h48d2_ffff);
    i_src.fire(p, s, g, m);
    rdlo(13, 16'hfffe);
    chk({31'h0, event_trigger[13]}, 32'h1);
    wr(SPR_CNT_BASE + 6'd13, 32'h5);
    chk({31'h0, event_trigger[13]}, 32'h0);
    @(negedge ref_clk);
    chk({31'h0, event_irq}, 32'h0);
  endtask

  task automatic t_mispredict();
    wr(SPR_SELECT, 32'h0);
    wr(SPR_CNT_BASE + 6'd6, 32'ha);
    clr();
    p.mispredict = 1'b1;
    i_src.fire(p, s, g, m);
    rdlo(6, 16'h9);
    wr(SPR_SELECT, 32'h4);
    i_src.fire(p, s, g, m);
    rdlo(6, 16'h9);
    p.static_predict_bit_miss = 1'b1;
    p.ex_pc = 32'h0000_0abc;
    i_src.fire(p, s, g, m);
    rd(SPR_CNT_BASE + 6'd6);
    chk(rd_val, 32'h02af_0008);
  endtask

  // fu stall, both proc port events and issue, singly and all at once
  task automatic t_union();
    logic [3:0] v;
    wr(SPR_SELECT, 32'h0080_0038);
    wr(SPR_CNT_BASE + 6'd11, 32'd20);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 5)
        wr(SPR_SELECT, 32'h0);
      v = (i < 4) ? 4'(1 << i) : 4'hf;
      clr();
      p.fu_stall = v[0];
      g.out_blocked[DIR_P] = v[1];
      m.out_blocked[DIR_P] = v[2];
      p.issue = v[3];
      i_src.fire(p, s, g, m);
      rdlo(11, 16'(19 - ((i < 5) ? i : 4)));
    end
  endtask

  // every code of the general west field; a foreign event first, then the match
  task automatic t_net();
    wr(SPR_SELECT, 32'h80);
    for (int c = 0; c < 8; c++)
    begin
      wr(SPR_NETCFG, 32'(c) << 3);
      wr(SPR_CNT_BASE + 6'd12, 32'd100);
      clr();
      g.route[DIR_S] = '1;
      g.out_blocked = 5'h1d;
      g.in_stuck = 5'h1d;
      i_src.fire(p, s, g, m);
      clr();
      if (c == 0)
        g.out_blocked[DIR_W] = 1'b1;
      else if (c == 7)
        g.in_stuck[DIR_W] = 1'b1;
      else
        g.route[DIR_W][(c == 6) ? DIR_N : c - 1] = 1'b1;
      i_src.fire(p, s, g, m);
      rdlo(12, 16'd99);
    end
  endtask

  task automatic t_filter();
    wr(SPR_FILTER, 32'h03ff_0081);
    wr(SPR_SELECT, 32'h0080_0008);
    wr(SPR_CNT_BASE + 6'd11, 32'h1);
    clr();
    p.fu_stall = 1'b1;
    p.rf_pc = 32'h104;
    i_src.fire(p, s, g, m);
    rdlo(11, 16'h1);
    p.rf_pc = 32'h100;
    i_src.fire(p, s, g, m);
    rdlo(11, 16'h0);
    // clear the captured pc so the next issue really wraps and sets the trigger
    wr(SPR_CNT_BASE + 6'd11, 32'h0);
    clr();
    p.issue = 1'b1;
    p.rf_pc = 32'h104;
    i_src.fire(p, s, g, m);
    rdlo(11, 16'hffff);
    wr(SPR_FILTER, 32'h03df_0000);
    i_src.fire(p, s, g, m);
    rdlo(11, 16'hffff);
    chk({31'h0, event_trigger[11]}, 32'h1);
  endtask

  // switch counters ignore a mismatching pc filter and capture the switch pc
  task automatic t_switch();
    wr(SPR_FILTER, 32'h03ff_0081);
    for (int k = 0; k < 3; k++)
    begin
      wr(SPR_CNT_BASE + 6'(7 + k), 32'd50);
      clr();
      s.pc = 32'h0000_0abc;
      s.stall = (k == 0);
      s.poss_mispredict = (k == 1);
      s.mispredict = (k == 2);
      i_src.fire(p, s, g, m);
      rd(SPR_CNT_BASE + 6'(7 + k));
      chk(rd_val, 32'h02af_0031);
    end
  endtask

  // two reads three edges apart must be three steps apart
  task automatic t_lfsr();
    rd(SPR_CNT_BASE + 6'd10);
    a = rd_val;
    rd(SPR_CNT_BASE + 6'd10);
    chk(rd_val, step(step(step(a))));
  endtask

  // pipeline stalls on counters 12 to 15, then storage network east and north
  task automatic t_stalls();
    logic [3:0] v;
    wr(SPR_SELECT, 32'h005f_7240);
    for (int k = 12; k < 16; k++)
      wr(SPR_CNT_BASE + 6'(k), 32'd10);
    clr();
    p.rf_pc = 32'h100;
    p.noncache_stall = 1'b1;
    p.imem_op_issue = 1'b1;
    i_src.fire(p, s, g, m);
    rd(SPR_CNT_BASE + 6'd12);
    chk(rd_val, 32'h0040_0009);
    rdlo(13, 16'h9);
    // one kind at a time, all at once, then all at once from a refused pc
    for (int i = 0; i < 6; i++)
    begin
      v = (i < 4) ? 4'(1 << i) : 4'hf;
      clr();
      p.rf_pc = (i == 5) ? 32'h104 : 32'h100;
      p.static_out_stall = v[0];
      p.general_dyn_out_port_stall = v[1];
      p.memory_dyn_out_port_stall = v[2];
      p.static_net_in_port_stall = v[0];
      p.static_net_in_port_second_stall = v[1];
      p.general_dyn_in_port_stall = v[2];
      p.memory_dyn_in_port_stall = v[3];
      i_src.fire(p, s, g, m);
      rdlo(14, 16'(9 - ((i < 3) ? i : ((i < 5) ? i - 1 : 3))));
      rdlo(15, 16'(9 - ((i < 5) ? i : 4)));
    end
    // network events ignore the pc filter but still capture the rf pc
    clr();
    p.rf_pc = 32'h104;
    m.out_blocked[DIR_E] = 1'b1;
    m.out_blocked[DIR_N] = 1'b1;
    i_src.fire(p, s, g, m);
    rd(SPR_CNT_BASE + 6'd14);
    chk(rd_val, 32'h0041_0005);
    rd(SPR_CNT_BASE + 6'd15);
    chk(rd_val, 32'h0041_0004);
  endtask

  // ********
  // main sequence
  // ********
  initial
  begin
    arst_n = 1'b0;
    spr_req = '0;
    clr();
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    t_regs();
    t_wrap();
    t_mispredict();
    t_union();
    t_net();
    t_filter();
    t_switch();
    t_lfsr();
    t_stalls();
    results();
  end
endmodule

`default_nettype wire
